// ==== hdl/l1c_top.sv ====
/*
  l1c_top: level-1 instruction and data cache control. Holds the two
  implementation control registers, routes lookups to one tag array per cache
  and tells the core whether each access hits, fills, or goes to the bus.
  assumes: single core clock; bus snoops and core accesses never overlap on the
  same cache in one cycle (snoop has priority).
*/
// Local design decisions: the register addresses and the address-and-strobe port.
`default_nettype none
module l1c_top (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // register port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_write,
  input  wire logic        i_reg_read,
  output logic      [31:0] o_reg_rdata,
  // instruction fetch
  input  wire logic        i_fetch_req,
  input  wire logic [19:0] i_fetch_addr,
  output logic             o_fetch_hit,
  output logic             o_fetch_fill,
  output logic             o_fetch_bus,
  output logic             o_fetch_burst,
  // data access
  input  wire logic        i_data_req,
  input  wire logic [19:0] i_data_addr,
  output logic             o_data_hit,
  output logic             o_data_fill,
  output logic             o_data_bus,
  // bus snoop
  input  wire logic        i_snoop_req,
  input  wire logic        i_snoop_icache,
  input  wire logic [19:0] i_snoop_addr,
  output logic             o_snoop_hit
);
  // shorthand for the cache geometry
  localparam int W = l1c_pkg::NUM_WAYS;
  localparam int SB = l1c_pkg::SET_BITS;

  // control words and pending flash requests
  logic [31:0] ctrl0, next_ctrl0;
  logic [31:0] ctrl2, next_ctrl2;
  logic [31:0] next_rdata;
  logic        i_fl_pend, next_i_fl_pend;
  logic        d_fl_pend, next_d_fl_pend;
  // per-cache routing
  logic        ic_snoop, dc_snoop;
  logic [19:0] ic_addr, dc_addr;
  // registered outcomes: fetch 2:0, snoop 3, burst 4, data 7:5
  logic [7:0]  next_resp, resp;

  // one lookup port per cache
  l1c_lookup_if ic_lk ();
  l1c_lookup_if dc_lk ();

  // ----------------------------------------
  // per-cache request routing
  // ----------------------------------------
  // snoops take the port ahead of core accesses; disabled cache drops them
  always_comb begin
    ic_snoop = i_snoop_req && i_snoop_icache;
    dc_snoop = i_snoop_req && !i_snoop_icache;
    ic_addr  = ic_snoop ? i_snoop_addr : i_fetch_addr;
    dc_addr  = dc_snoop ? i_snoop_addr : i_data_addr;
  end

  // instruction cache port; control fields come straight from the words
  assign ic_lk.req         = ic_snoop || i_fetch_req;
  assign ic_lk.set         = ic_addr[SB-1:0];
  assign ic_lk.tag         = ic_addr[19:4];
  assign ic_lk.enable      = ctrl0[l1c_pkg::BIT_ICACHE_ENABLE];
  assign ic_lk.lock_all    = ctrl0[l1c_pkg::BIT_ICACHE_LOCK_ALL];
  assign ic_lk.way_lock    = ctrl2[l1c_pkg::POS_ICACHE_WAY_LOCK +: W];
  assign ic_lk.protect     = ctrl2[l1c_pkg::BIT_ICACHE_LOCKED_WAY_PROT];
  assign ic_lk.snoop_inv   = ic_snoop;
  assign ic_lk.flash_start = i_fl_pend && !ic_lk.flash_busy;

  // data cache port, no locked-way protection on this side
  assign dc_lk.req         = dc_snoop || i_data_req;
  assign dc_lk.set         = dc_addr[SB-1:0];
  assign dc_lk.tag         = dc_addr[19:4];
  assign dc_lk.enable      = ctrl0[l1c_pkg::BIT_DCACHE_ENABLE];
  assign dc_lk.lock_all    = ctrl0[l1c_pkg::BIT_DCACHE_LOCK_ALL];
  assign dc_lk.way_lock    = ctrl2[l1c_pkg::POS_DCACHE_WAY_LOCK +: W];
  assign dc_lk.protect     = 1'b0;   // protection exists for the icache only
  assign dc_lk.snoop_inv   = dc_snoop;
  assign dc_lk.flash_start = d_fl_pend && !dc_lk.flash_busy;

  // identical tag arrays, each walks its own flash invalidate
  l1c_tag_array u_icache (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .lk        (ic_lk)
  );

  l1c_tag_array u_dcache (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .lk        (dc_lk)
  );

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // a write of 1 to a flash bit arms a walk; the bit self-clears when done
  always_comb begin
    next_ctrl0     = ctrl0;
    next_ctrl2     = ctrl2;
    next_i_fl_pend = i_fl_pend;
    next_d_fl_pend = d_fl_pend;
    // a walk that starts consumes its request
    if (ic_lk.flash_start) begin
      next_i_fl_pend = 1'b0;
    end
    if (dc_lk.flash_start) begin
      next_d_fl_pend = 1'b0;
    end
    // writes keep only the bits this block stores
    if (i_reg_write && i_reg_addr == l1c_pkg::ADDR_CTRL0) begin
      next_ctrl0 = i_reg_wdata & 32'h0000_003F;
      if (i_reg_wdata[l1c_pkg::BIT_ICACHE_FLASH_INVALIDATE]) begin
        next_i_fl_pend = 1'b1;
      end
      if (i_reg_wdata[l1c_pkg::BIT_DCACHE_FLASH_INVALIDATE]) begin
        next_d_fl_pend = 1'b1;
      end
    end else if (i_reg_write && i_reg_addr == l1c_pkg::ADDR_CTRL2) begin
      next_ctrl2 = i_reg_wdata & 32'h00FF_FF03;
    end
    // flash bits read back as busy until the walk is over; a fresh write wins
    next_ctrl0[l1c_pkg::BIT_ICACHE_FLASH_INVALIDATE] = next_i_fl_pend || ic_lk.flash_start
        || (ic_lk.flash_busy && ctrl0[l1c_pkg::BIT_ICACHE_FLASH_INVALIDATE]);
    next_ctrl0[l1c_pkg::BIT_DCACHE_FLASH_INVALIDATE] = next_d_fl_pend || dc_lk.flash_start
        || (dc_lk.flash_busy && ctrl0[l1c_pkg::BIT_DCACHE_FLASH_INVALIDATE]);
  end

  // read data, one cycle after the strobe; unmapped reads return zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_reg_read) begin
      if (i_reg_addr == l1c_pkg::ADDR_CTRL0) begin
        next_rdata = ctrl0;
      end else if (i_reg_addr == l1c_pkg::ADDR_CTRL2) begin
        next_rdata = ctrl2;
      // status bits follow the walks live
      end else if (i_reg_addr == l1c_pkg::ADDR_STATUS) begin
        next_rdata = {30'h0, dc_lk.flash_busy, ic_lk.flash_busy};
      end
    end
  end

  // ----------------------------------------
  // access outcomes
  // ----------------------------------------
  // outcomes are registered, so they stand the cycle after the request
  always_comb begin
    next_resp = '0;
    // a fetch that meets an icache snoop gets no answer
    if (i_fetch_req && !ic_snoop) begin
      next_resp[0] = ic_lk.result == l1c_pkg::L1C_RES_HIT;
      next_resp[1] = ic_lk.result == l1c_pkg::L1C_RES_FILL;
      next_resp[2] = ic_lk.result == l1c_pkg::L1C_RES_BUS;
    end
    // snoop answer is the hit of the addressed cache only
    if (i_snoop_req) begin
      next_resp[3] = i_snoop_icache ? ic_lk.hit : dc_lk.hit;
    end
    // data side mirrors the fetch side
    if (i_data_req && !dc_snoop) begin
      next_resp[5] = dc_lk.result == l1c_pkg::L1C_RES_HIT;
      next_resp[6] = dc_lk.result == l1c_pkg::L1C_RES_FILL;
      next_resp[7] = dc_lk.result == l1c_pkg::L1C_RES_BUS;
    end
    // burst kind only means something when the fetch goes out
    next_resp[4] = next_resp[2] && ctrl2[l1c_pkg::BIT_FETCH_BURST_ENABLE];
  end

  // response and control registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // both caches start disabled
      ctrl0         <= l1c_pkg::RESET_CTRL0;
      ctrl2         <= l1c_pkg::RESET_CTRL2;
      i_fl_pend     <= 1'b0;
      d_fl_pend     <= 1'b0;
      o_reg_rdata   <= 32'h0000_0000;
      resp          <= '0;
    end else begin
      ctrl0         <= next_ctrl0;
      ctrl2         <= next_ctrl2;
      i_fl_pend     <= next_i_fl_pend;
      d_fl_pend     <= next_d_fl_pend;
      o_reg_rdata   <= next_rdata;
      resp          <= next_resp;
    end
  end

  // outcome pulses come straight from the response register
  assign o_fetch_hit   = resp[0];
  assign o_fetch_fill  = resp[1];
  assign o_fetch_bus   = resp[2];
  assign o_snoop_hit   = resp[3];
  assign o_fetch_burst = resp[4];
  assign o_data_hit    = resp[5];
  assign o_data_fill   = resp[6];
  assign o_data_bus    = resp[7];
endmodule : l1c_top
`default_nettype wire

// ==== hdl/l1c_pkg.sv ====
/*
  l1c_pkg: shared constants for the level-1 cache control block, covering the
  register map, field positions, reset values and cache geometry.
  assumes: core clock domain only; consumers refer to names as l1c_pkg::name.
*/
`default_nettype none
package l1c_pkg;
  // ----------------------------------------
  // register map (word offsets on the plain port)
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL0  = 4'h0;   // hw_impl_control_0
  localparam logic [3:0] ADDR_CTRL2  = 4'h1;   // hw_impl_control_2
  localparam logic [3:0] ADDR_STATUS = 4'h2;   // read-only status
  // ----------------------------------------
  // hw_impl_control_0 fields
  // ----------------------------------------
  localparam int BIT_ICACHE_ENABLE           = 0;
  localparam int BIT_DCACHE_ENABLE           = 1;
  localparam int BIT_ICACHE_LOCK_ALL         = 2;
  localparam int BIT_DCACHE_LOCK_ALL         = 3;
  localparam int BIT_ICACHE_FLASH_INVALIDATE = 4;
  localparam int BIT_DCACHE_FLASH_INVALIDATE = 5;
  // ----------------------------------------
  // hw_impl_control_2 fields
  // ----------------------------------------
  localparam int BIT_FETCH_BURST_ENABLE      = 0;
  localparam int BIT_ICACHE_LOCKED_WAY_PROT  = 1;
  localparam int POS_ICACHE_WAY_LOCK         = 8;
  localparam int POS_DCACHE_WAY_LOCK         = 16;
  // ----------------------------------------
  // reset values and geometry
  // ----------------------------------------
  localparam logic [31:0] RESET_CTRL0 = 32'h0000_0000;  // both caches off
  localparam logic [31:0] RESET_CTRL2 = 32'h0000_0000;
  localparam int          NUM_WAYS    = 4;
  localparam int          NUM_SETS    = 16;
  localparam int          SET_BITS    = 4;
  localparam int          WAY_BITS    = 2;
  localparam logic [1:0]  PLRU_WAY0   = 2'h0;           // replacement restarts at way 0
  // ----------------------------------------
  // access outcomes
  // ----------------------------------------
  typedef enum logic [1:0] {
    L1C_RES_HIT,
    L1C_RES_FILL,
    L1C_RES_BUS
  } l1c_res_e;
endpackage : l1c_pkg
`default_nettype wire

// ==== hdl/l1c_lookup_if.sv ====
/*
  l1c_lookup_if: carries one cache's lookup request and outcome between the
  control top and its per-cache tag array.
  assumes: single clock, requests are one-cycle pulses.
*/
`default_nettype none
interface l1c_lookup_if;
  logic                          req;
  logic [l1c_pkg::SET_BITS-1:0]  set;
  logic [15:0]                   tag;
  logic                          hit;
  logic [l1c_pkg::WAY_BITS-1:0]  hit_way;
  logic                          enable;
  logic                          lock_all;
  logic [l1c_pkg::NUM_WAYS-1:0]  way_lock;
  logic                          protect;
  logic                          snoop_inv;
  logic                          flash_start;
  logic                          flash_busy;
  l1c_pkg::l1c_res_e             result;
  logic [l1c_pkg::WAY_BITS-1:0]  fill_way;
  modport ctrl (output req, set, tag, enable, lock_all, way_lock, protect, snoop_inv, flash_start,
                input hit, hit_way, flash_busy, result, fill_way);
  modport arr  (input req, set, tag, enable, lock_all, way_lock, protect, snoop_inv, flash_start,
                output hit, hit_way, flash_busy, result, fill_way);
endinterface : l1c_lookup_if
`default_nettype wire

// ==== hdl/l1c_tag_array.sv ====
/*
  l1c_tag_array: tag, valid and pseudo-LRU state for one cache, with lookup,
  allocation, snoop invalidate and a one-set-per-cycle flash invalidate walk.
  assumes: driven by l1c_top through l1c_lookup_if; single clock domain.
*/
`default_nettype none
module l1c_tag_array (
  // clock and reset
  input  wire logic     i_clk,
  input  wire logic     i_reset_n,
  // lookup port
  l1c_lookup_if.arr     lk
);
  localparam int W = l1c_pkg::NUM_WAYS;
  localparam int S = l1c_pkg::NUM_SETS;

  typedef enum {L1C_IDLE, L1C_WALK} l1c_fi_e;

  logic [15:0]                   tags      [S][W];
  logic [W-1:0]                  valid     [S];
  logic [l1c_pkg::WAY_BITS-1:0]  plru      [S];
  logic [15:0]                   next_tags [S][W];
  logic [W-1:0]                  next_valid[S];
  logic [l1c_pkg::WAY_BITS-1:0]  next_plru [S];
  l1c_fi_e                       state, next_state;
  logic [l1c_pkg::SET_BITS-1:0]  walk, next_walk;
  logic [W-1:0]                  match;
  logic [l1c_pkg::WAY_BITS-1:0]  victim;
  logic                          can_alloc;

  // ----------------------------------------
  // hit detection
  // ----------------------------------------
  // disabled cache ignores its tag state completely
  always_comb begin
    match = '0;
    lk.hit_way = '0;
    for (int w = 0; w < W; w++) begin
      match[w] = lk.enable && valid[lk.set][w] && tags[lk.set][w] == lk.tag;
      if (match[w]) begin
        lk.hit_way = l1c_pkg::WAY_BITS'(w);
      end
    end
    lk.hit = |match;
  end

  // victim: plru pointer, skipping locked ways
  always_comb begin
    victim = plru[lk.set];
    can_alloc = 1'b0;
    for (int k = W - 1; k >= 0; k--) begin
      if (!lk.way_lock[l1c_pkg::WAY_BITS'(plru[lk.set] + k)]) begin
        victim = l1c_pkg::WAY_BITS'(plru[lk.set] + k);
        can_alloc = 1'b1;
      end
    end
    if (lk.lock_all) begin
      can_alloc = 1'b0;
    end
  end

  // outcome classification for the control top
  always_comb begin
    lk.fill_way = victim;
    if (lk.hit) begin
      lk.result = l1c_pkg::L1C_RES_HIT;
    end else if (lk.enable && can_alloc) begin
      lk.result = l1c_pkg::L1C_RES_FILL;
    end else begin
      lk.result = l1c_pkg::L1C_RES_BUS;
    end
  end

  // ----------------------------------------
  // next state of tag store
  // ----------------------------------------
  always_comb begin
    next_tags  = tags;
    next_valid = valid;
    next_plru  = plru;
    next_state = state;
    next_walk  = walk;
    case (state)
      L1C_IDLE: begin
        if (lk.flash_start) begin
          next_state = L1C_WALK;
          next_walk  = '0;
        end else if (lk.req && lk.enable) begin
          if (lk.hit) begin
            if (lk.snoop_inv) begin
              next_valid[lk.set][lk.hit_way] = 1'b0;
            end else begin
              next_plru[lk.set] = l1c_pkg::WAY_BITS'(lk.hit_way + 1);
            end
          end else if (!lk.snoop_inv && lk.result == l1c_pkg::L1C_RES_FILL) begin
            next_tags[lk.set][victim]  = lk.tag;
            next_valid[lk.set][victim] = 1'b1;
            next_plru[lk.set]          = l1c_pkg::WAY_BITS'(victim + 1);
          end
        end
      end
      L1C_WALK: begin
        for (int w = 0; w < W; w++) begin
          // protected locked ways survive the invalidate
          if (!(lk.protect && lk.way_lock[w])) begin
            next_valid[walk][w] = 1'b0;
          end
        end
        next_plru[walk] = l1c_pkg::PLRU_WAY0;
        next_walk = l1c_pkg::SET_BITS'(walk + 1);
        if (walk == l1c_pkg::SET_BITS'(S - 1)) begin
          next_state = L1C_IDLE;
        end
      end
      default: next_state = L1C_IDLE;
    endcase
  end

  assign lk.flash_busy = (state == L1C_WALK);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= L1C_IDLE;
      walk  <= '0;
      for (int s = 0; s < S; s++) begin
        valid[s] <= '0;
        plru[s]  <= l1c_pkg::PLRU_WAY0;
        for (int w = 0; w < W; w++) begin
          tags[s][w] <= '0;
        end
      end
    end else begin
      state <= next_state;
      walk  <= next_walk;
      tags  <= next_tags;
      valid <= next_valid;
      plru  <= next_plru;
    end
  end
endmodule : l1c_tag_array
`default_nettype wire

// ==== test/l1c_top_properties.sv ====
/*
  l1c_props: port-level timing checks for l1c_top, bound in below.
  assumes: control bits change only through the plain register port.
*/
`default_nettype none
module l1c_props (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  // register port
  input wire logic [3:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic        i_reg_write,
  input wire logic        i_reg_read,
  input wire logic [31:0] o_reg_rdata,
  // core accesses
  input wire logic        i_fetch_req,
  input wire logic [19:0] i_fetch_addr,
  input wire logic        o_fetch_hit,
  input wire logic        o_fetch_fill,
  input wire logic        o_fetch_bus,
  input wire logic        o_fetch_burst,
  input wire logic        i_data_req,
  input wire logic [19:0] i_data_addr,
  input wire logic        o_data_hit,
  input wire logic        o_data_fill,
  input wire logic        o_data_bus,
  // bus snoop
  input wire logic        i_snoop_req,
  input wire logic        i_snoop_icache,
  input wire logic [19:0] i_snoop_addr,
  input wire logic        o_snoop_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // shadow of the control bits
  // ------
  logic [3:0] ctl, next_ctl;
  logic       burst, next_burst;
  logic [4:0] fcnt, next_fcnt;
  logic       rd0;
  // read of control word 0
  assign rd0 = i_reg_read && i_reg_addr == l1c_pkg::ADDR_CTRL0;
  // countdown only brackets the walk with margin, it does not time it exactly
  always_comb begin
    next_ctl   = ctl;
    next_burst = burst;
    next_fcnt  = (fcnt != 5'h00) ? fcnt - 5'h01 : 5'h00;
    if (i_reg_write && i_reg_addr == l1c_pkg::ADDR_CTRL0) begin
      next_ctl = i_reg_wdata[3:0];
      if (i_reg_wdata[l1c_pkg::BIT_ICACHE_FLASH_INVALIDATE]) begin
        next_fcnt = 5'h14;
      end
    end
    if (i_reg_write && i_reg_addr == l1c_pkg::ADDR_CTRL2) begin
      next_burst = i_reg_wdata[l1c_pkg::BIT_FETCH_BURST_ENABLE];
    end
  end
  // register only
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctl   <= 4'h0;
      burst <= 1'b0;
      fcnt  <= 5'h00;
    end else begin
      ctl   <= next_ctl;
      burst <= next_burst;
      fcnt  <= next_fcnt;
    end
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  fetch_off_bus_a: assert property (i_fetch_req && !ctl[0] && !(i_snoop_req && i_snoop_icache)
    |=> o_fetch_bus && !o_fetch_hit && !o_fetch_fill) else $error("fetch with icache off stayed off the bus");
  burst_select_a: assert property (o_fetch_bus |-> o_fetch_burst == $past(burst))
    else $error("fetch burst kind differs from setting");
  data_off_bus_a: assert property (i_data_req && !ctl[1] && !(i_snoop_req && !i_snoop_icache)
    |=> o_data_bus && !o_data_hit && !o_data_fill) else $error("data access used a disabled cache");
  snoop_off_a: assert property (i_snoop_req && !(i_snoop_icache ? ctl[0] : ctl[1]) |=> !o_snoop_hit)
    else $error("snoop hit in a disabled cache");
  ctrl_readback_a: assert property (rd0 |=> o_reg_rdata[3:0] == $past(ctl))
    else $error("control bits read back wrong");
  icache_lock_all_no_fill_a: assert property (i_fetch_req && ctl[2] |=> !o_fetch_fill)
    else $error("locked icache allocated a line");
  flash_busy_a: assert property (rd0 && fcnt >= 5'h08 |=> o_reg_rdata[4])
    else $error("flash bit cleared too early");
  flash_done_a: assert property (rd0 && fcnt == 5'h00 |=> !o_reg_rdata[4])
    else $error("flash bit did not clear");
endmodule : l1c_props
bind l1c_top l1c_props l1c_props_i (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
  .i_fetch_req(i_fetch_req), .i_fetch_addr(i_fetch_addr), .o_fetch_hit(o_fetch_hit),
  .o_fetch_fill(o_fetch_fill), .o_fetch_bus(o_fetch_bus), .o_fetch_burst(o_fetch_burst),
  .i_data_req(i_data_req), .i_data_addr(i_data_addr), .o_data_hit(o_data_hit),
  .o_data_fill(o_data_fill), .o_data_bus(o_data_bus), .i_snoop_req(i_snoop_req),
  .i_snoop_icache(i_snoop_icache), .i_snoop_addr(i_snoop_addr), .o_snoop_hit(o_snoop_hit)
);
`default_nettype wire

// ==== test/l1c_bus_model.sv ====
/*
  l1c_bus_model: stand-in for the coherent system bus; counts fetch beats
  and acts as the snooping master.
  assumes: the block answers a snoop one cycle after the request.
*/
`default_nettype none
module l1c_bus_model (
  // clock
  input  wire logic        i_clk,
  // bus requests from the block
  input  wire logic        i_fetch_bus,
  input  wire logic        i_fetch_burst,
  input  wire logic        i_snoop_hit,
  // snoop master
  output logic             o_snoop_req,
  output logic             o_snoop_icache,
  output logic      [19:0] o_snoop_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  int beats = 0;
  // idle at time zero
  initial begin
    o_snoop_req    = 1'b0;
    o_snoop_icache = 1'b0;
    o_snoop_addr   = 20'h00000;
  end
  // a burst moves four beats, a single beat one
  always @(posedge i_clk) begin
    if (i_fetch_bus) begin
      beats <= beats + (i_fetch_burst ? 4 : 1);
    end
  end
  // one-cycle snoop; address inverted afterwards so nothing stale looks valid
  task automatic snoop(input logic ic, input logic [19:0] a, output logic hit);
    @(posedge i_clk);
    o_snoop_req    <= 1'b1;
    o_snoop_icache <= ic;
    o_snoop_addr   <= a;
    @(posedge i_clk);
    o_snoop_req  <= 1'b0;
    o_snoop_addr <= ~a;
    @(negedge i_clk);
    hit = i_snoop_hit;
  endtask : snoop
endmodule : l1c_bus_model
`default_nettype wire

// ==== test/l1c_top_tb_top.sv ====
/*
  l1c_top_tb_top: directed checks of l1c_top through its register port,
  access ports and the bus model's snoops.
  assumes: 50 MHz clock, every access answered one cycle after its request.
*/
`default_nettype none
module l1c_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] C0 = l1c_pkg::ADDR_CTRL0;
  localparam logic [3:0] C2 = l1c_pkg::ADDR_CTRL2;
  localparam logic [3:0] HIT = 4'h8, FILL = 4'h4, ONE = 4'h2, BURST = 4'h3;
  logic        clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [3:0]  reg_addr = 4'h0, r;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic        fetch_req = 1'b0, data_req = 1'b0, h;
  logic [19:0] fetch_addr = 20'h0, data_addr = 20'h0, snoop_addr;
  logic        fetch_hit, fetch_fill, fetch_bus, fetch_burst, data_hit, data_fill, data_bus;
  logic        snoop_req, snoop_icache, snoop_hit;
  int          err_count = 0, comparisons = 0;
  l1c_top l1c_top_i (
    .i_clk(clk), .i_reset_n(rst_n), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_write(reg_write), .i_reg_read(reg_read), .o_reg_rdata(reg_rdata),
    .i_fetch_req(fetch_req), .i_fetch_addr(fetch_addr), .o_fetch_hit(fetch_hit),
    .o_fetch_fill(fetch_fill), .o_fetch_bus(fetch_bus), .o_fetch_burst(fetch_burst),
    .i_data_req(data_req), .i_data_addr(data_addr), .o_data_hit(data_hit),
    .o_data_fill(data_fill), .o_data_bus(data_bus), .i_snoop_req(snoop_req),
    .i_snoop_icache(snoop_icache), .i_snoop_addr(snoop_addr), .o_snoop_hit(snoop_hit)
  );
  l1c_bus_model l1c_bus_model_i (
    .i_clk(clk), .i_fetch_bus(fetch_bus), .i_fetch_burst(fetch_burst), .i_snoop_hit(snoop_hit),
    .o_snoop_req(snoop_req), .o_snoop_icache(snoop_icache), .o_snoop_addr(snoop_addr)
  );
  // 20 ns clock
  initial begin
    forever #10 clk = ~clk;
  end
  // ------
  // bus tasks
  // ------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  // result packs hit, fill, bus and burst
  task automatic acc(input logic ic, input logic [19:0] a);
    @(posedge clk);
    fetch_req  <= ic;
    data_req   <= !ic;
    fetch_addr <= a;
    data_addr  <= a;
    @(posedge clk);
    fetch_req <= 1'b0;
    data_req  <= 1'b0;
    @(negedge clk);
    r = ic ? {fetch_hit, fetch_fill, fetch_bus, fetch_burst} : {data_hit, data_fill, data_bus, 1'b0};
  endtask : acc
  // polls a flash bit, bounded so a stuck bit cannot hang the run
  task automatic wait_flash(input int b);
    int n;
    n = 0;
    rd(C0);
    while (d[b] === 1'b1 && n < 40) begin
      rd(C0);
      n++;
    end
  endtask : wait_flash
  // ------
  // scenarios
  // ------
  task automatic t_reset_state;
    rd(C0);
    chk("ctrl0", d, 32'h0);
    rd(C2);
    chk("ctrl2", d, 32'h0);
    rd(4'hF);
    chk("unmapped", d, 32'h0);
    acc(1'b1, 20'h12343);
    chk("fetch_single", r, ONE);
    wr(C2, 32'h1);
    acc(1'b1, 20'h12343);
    chk("fetch_burst", r, BURST);
    acc(1'b0, 20'h05677);
    chk("data_off", r, ONE);
    l1c_bus_model_i.snoop(1'b1, 20'h12343, h);
    chk("snoop_off", h, 1'b0);
    chk("beats", l1c_bus_model_i.beats, 32'h5);
  endtask : t_reset_state
  task automatic t_fill_snoop;
    wr(C0, 32'h3);
    acc(1'b1, 20'h12343);
    chk("first_fetch", r, FILL);
    acc(1'b1, 20'h12343);
    chk("second_fetch", r, HIT);
    l1c_bus_model_i.snoop(1'b1, 20'h12343, h);
    chk("snoop_on", h, 1'b1);
    acc(1'b1, 20'h12343);
    chk("refetch", r, FILL);
    acc(1'b0, 20'h05677);
    chk("data_fill", r, FILL);
    wr(C0, 32'h0);
    acc(1'b1, 20'h12343);
    chk("ifetch_off", r, BURST);
    acc(1'b0, 20'h05677);
    chk("data_off2", r, ONE);
    l1c_bus_model_i.snoop(1'b0, 20'h05677, h);
    chk("dsnoop_off", h, 1'b0);
    wr(C0, 32'h3);
    acc(1'b1, 20'h12343);
    chk("ion_again", r, HIT);
    acc(1'b0, 20'h05677);
    chk("don_again", r, HIT);
  endtask : t_fill_snoop
  task automatic t_lock;
    wr(C0, 32'hB);
    acc(1'b0, 20'h05677);
    chk("lock_hit", r, HIT);
    acc(1'b0, 20'h09877);
    chk("lock_miss", r, ONE);
    acc(1'b0, 20'h09877);
    chk("lock_again", r, ONE);
    wr(C0, 32'h7);
    acc(1'b1, 20'h0AB43);
    chk("icache_lock_all_miss", r, BURST);
    wr(C0, 32'h3);
    wr(C2, 32'h1 | (32'hF << l1c_pkg::POS_DCACHE_WAY_LOCK));
    acc(1'b0, 20'h09877);
    chk("ways_locked", r, ONE);
    acc(1'b0, 20'h05677);
    chk("locked_way_hit", r, HIT);
    wr(C2, 32'h1);
  endtask : t_lock
  // a line placed right after a flash lands in way 0, which protection then keeps
  task automatic t_flash;
    acc(1'b1, 20'h00B05);
    chk("x_fill", r, FILL);
    wr(C0, 32'h13);
    rd(C0);
    chk("iflash_set", d[4], 1'b1);
    wait_flash(4);
    chk("iflash_clear", d[4], 1'b0);
    acc(1'b1, 20'h00A05);
    chk("a_fill", r, FILL);
    acc(1'b1, 20'h00B05);
    chk("x_gone", r, FILL);
    wr(C2, 32'h3 | (32'h1 << l1c_pkg::POS_ICACHE_WAY_LOCK));
    wr(C0, 32'h13);
    wait_flash(4);
    acc(1'b1, 20'h00A05);
    chk("protected", r, HIT);
    acc(1'b1, 20'h00B05);
    chk("unprotected", r, FILL);
    wr(C0, 32'h23);
    wait_flash(5);
    chk("dflash_clear", d[5], 1'b0);
    acc(1'b0, 20'h05677);
    chk("d_gone", r, FILL);
  endtask : t_flash
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_state();
    t_fill_snoop();
    t_lock();
    t_flash();
    test_done();
  end
  // watchdog: the tests need well under 1500 cycles
  initial begin
    #60000;
    err_count++;
    test_done();
  end
endmodule : l1c_top_tb_top
`default_nettype wire
